/* File: rtl/bdm_top.sv */
// banked data memory: address generation, bank pointer and 4 Kbyte store
`timescale 1ns/1ps
`include "bdm_regs.svh"

// Behaviour
// RULE_01: 12-bit byte address, 4096-byte static RAM
// RULE_02: sixteen banks of 256 bytes, all present
// RULE_03: unimplemented locations read back as zero
// RULE_04: banked address is bank pointer plus operand
// RULE_05: bank pointer upper nibble reads zero, unwritable
// RULE_06: load-bank-literal writes bank pointer directly
// RULE_07: absent bank drops writes, flags still update
// RULE_08: full-address move ignores the bank pointer
// RULE_09: fast map: low 96 bank 0, rest bank 15
// RULE_10: access bit 1 banked, 0 fast map
// RULE_11: fast map access finishes in one cycle
// RULE_12: F5Ah-F5Fh unreachable through the fast map
// RULE_13: extended set swaps in modified fast mapping
// RULE_14: banked write to FF9h hits program counter low
// RULE_15: read in second quarter, write in fourth
// RULE_16: effective address resolved combinationally before read
module bdm_top
  import bdm_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire bdm_op_t OP_KIND,
  input wire logic ACCESS_SEL,
  input wire logic [7:0] OPERAND,
  input wire logic [11:0] SRC_ADDR,
  input wire logic [11:0] DST_ADDR,
  input wire logic [7:0] LITERAL,
  input wire logic WR_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic EXTENDED_ISA_ENABLE,
  input wire logic [11:0] EXT_BASE,
  output logic [1:0] PHASE,
  output logic [7:0] RD_DATA,
  output logic [11:0] EFF_ADDR,
  output logic [7:0] BANK_POINTER,
  output logic FLAGS_UPDATE,
  output logic PC_LOW_WRITE,
  output logic [7:0] PC_LOW_DATA
);

  // whole data space; general purpose area is not cleared by reset
  logic [7:0] mem [0:`BDM_MEM_DEPTH-1]; // [RULE_01] [RULE_02]
  logic [1:0] phase;
  logic [3:0] bank_pointer;

  function automatic logic bank_present(input logic [11:0] addr);
    logic [15:0] impl;
    impl = `BDM_BANK_IMPL;
    bank_present = impl[addr[11:8]];
  endfunction

  // standard fast map; operands from 60h up land in bank 15, so the
  // bank 15 slots below F60h can never be reached this way
  function automatic logic [11:0] fast_map(input logic [7:0] off);
    if (off < `BDM_ACCESS_SPLIT) begin
      fast_map = {`BDM_GPR_BANK, off}; // [RULE_09]
    end else begin
      fast_map = {`BDM_SFR_BANK, off}; // [RULE_09] [RULE_12]
    end
  endfunction

  wire q2_en = (phase == `BDM_PH_Q2);
  wire q4_en = (phase == `BDM_PH_Q4);
  wire is_file = (OP_KIND == BDM_OP_FILE);
  wire is_move = (OP_KIND == BDM_OP_MOVE_FULL);
  wire is_load = (OP_KIND == BDM_OP_LOAD_BANK);

  // the extended set only relocates the low part of the fast map; the
  // core supplies the base and the base plus operand add is done here
  wire ext_low = EXTENDED_ISA_ENABLE && (OPERAND < `BDM_ACCESS_SPLIT);
  wire [11:0] ext_addr = 12'(EXT_BASE + {4'h0, OPERAND}); // [RULE_13]
  wire [11:0] bank_addr = {bank_pointer, OPERAND}; // [RULE_04]
  wire [11:0] fast_addr = ext_low ? ext_addr : fast_map(OPERAND);
  // no clocked stage in the path: the address is ready within Q1
  wire [11:0] file_addr =
    ACCESS_SEL ? bank_addr : fast_addr; // [RULE_10] [RULE_11] [RULE_16]
  wire [11:0] rd_addr = is_move ? SRC_ADDR : file_addr; // [RULE_08]
  wire [11:0] wr_addr = is_move ? DST_ADDR : file_addr; // [RULE_08]

  wire rd_is_bp = (rd_addr == `BDM_BANK_PTR_ADDR);
  wire [7:0] rd_word = rd_is_bp ? {4'h0, bank_pointer} :
                       bank_present(rd_addr) ? mem[rd_addr] :
                       8'h00; // [RULE_03] [RULE_05] [RULE_07]
  // a move writes what it read in Q2; other ops write the core's result
  wire [7:0] wr_word = is_move ? RD_DATA : WR_DATA;
  wire wr_go = q4_en && ((is_file && WR_EN) || is_move); // [RULE_15]
  wire mem_we = wr_go && bank_present(wr_addr); // [RULE_07]
  wire bp_we = wr_go && (wr_addr == `BDM_BANK_PTR_ADDR);
  wire pcl_we = wr_go && (wr_addr == `BDM_PC_LOW_ADDR); // [RULE_14]

  wire [3:0] next_bank_pointer = (q4_en && is_load) ? LITERAL[3:0] :
                                 bp_we ? wr_word[3:0] :
                                 bank_pointer; // [RULE_05] [RULE_06]

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      phase <= `BDM_PH_Q1;
    end else begin
      phase <= 2'(phase + 2'h1); // [RULE_15]
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bank_pointer <= `BDM_BP_RESET;
    end else begin
      bank_pointer <= next_bank_pointer;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[wr_addr] <= wr_word; // [RULE_07] [RULE_15]
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA <= 8'h00;
    end else if (q2_en && (is_file || is_move)) begin
      RD_DATA <= rd_word; // [RULE_15]
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PHASE <= `BDM_PH_Q1;
      EFF_ADDR <= 12'h000;
      BANK_POINTER <= 8'h00;
      FLAGS_UPDATE <= 1'b0;
      PC_LOW_WRITE <= 1'b0;
      PC_LOW_DATA <= 8'h00;
    end else begin
      PHASE <= 2'(phase + 2'h1);
      EFF_ADDR <= q4_en ? wr_addr : rd_addr;
      BANK_POINTER <= {4'h0, next_bank_pointer}; // [RULE_05]
      FLAGS_UPDATE <= q4_en && is_file; // [RULE_07]
      PC_LOW_WRITE <= pcl_we; // [RULE_14]
      PC_LOW_DATA <= pcl_we ? wr_word : PC_LOW_DATA;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  a_bp_upper_zero: assert property (BANK_POINTER[7:4] == 4'h0) // [RULE_05]
    else $error("bank pointer upper nibble not zero");
  a_load_bank_lit: assert property (q4_en && is_load |=> // [RULE_06]
    BANK_POINTER == {4'h0, $past(LITERAL[3:0])})
    else $error("load-bank-literal did not reach bank pointer");
  a_banked_addr: assert property (ACCESS_SEL && !is_move |-> // [RULE_04]
    rd_addr[11:8] == BANK_POINTER[3:0] && rd_addr[7:0] == OPERAND)
    else $error("banked address not bank pointer plus operand");
  a_fast_low: assert property (!ACCESS_SEL && !is_move && // [RULE_09]
    !EXTENDED_ISA_ENABLE && OPERAND < 8'h60 |-> rd_addr == {4'h0, OPERAND})
    else $error("fast map low half not in bank 0");
  a_fast_high_sfr: assert property (!ACCESS_SEL && !is_move && // [RULE_12]
    OPERAND >= 8'h60 |-> rd_addr[11:8] == 4'hF && rd_addr >= 12'hF60)
    else $error("fast map high half outside F60h-FFFh");
  a_full_move: assert property (is_move |-> // [RULE_08]
    rd_addr == SRC_ADDR && wr_addr == DST_ADDR)
    else $error("full move address depends on bank pointer");
  a_phase_order: assert property (PHASE == 2'h1 |=> // [RULE_15]
    PHASE == 2'h2 ##1 PHASE == 2'h3 ##1 PHASE == 2'h0)
    else $error("quarter phases out of order");
  a_flags_pulse: assert property (q4_en && is_file |=> // [RULE_07]
    FLAGS_UPDATE ##1 !FLAGS_UPDATE)
    else $error("flags update pulse missing");
  a_pcl_hit: assert property (q4_en && is_file && WR_EN && ACCESS_SEL &&
    BANK_POINTER[3:0] == 4'hF && OPERAND == 8'hF9 |=> // [RULE_14]
    PC_LOW_WRITE && PC_LOW_DATA == $past(WR_DATA))
    else $error("banked write to FF9h missed program counter low");
  a_read_bp: assert property (q2_en && is_file && // [RULE_05]
    rd_addr == 12'hFE0 |=> RD_DATA == {4'h0, $past(bank_pointer)})
    else $error("bank pointer read back wrong");

  c_fast_sfr: cover property (q4_en && is_file && !ACCESS_SEL &&
    OPERAND >= 8'h60);
  c_banked_write: cover property (q4_en && is_file && ACCESS_SEL && WR_EN);
  c_move_full: cover property (q4_en && is_move);
  c_load_bank: cover property (q4_en && is_load && LITERAL[7:4] != 4'h0);
  c_ext_map: cover property (q2_en && ext_low && !ACCESS_SEL && !is_move);

  // the output copy of the quarter counter must never drift from it
  a_phase_match: assert property (PHASE == phase) // [RULE_15]
    else $error("phase output differs from quarter counter");

  // read data may only move at the operand read edge
  a_rd_hold: assert property (!q2_en |=> // [RULE_15]
    RD_DATA == $past(RD_DATA))
    else $error("read data changed outside operand read");

  // result side effects only ever appear right after a Q4 edge
  a_pcl_after_q4: assert property (PC_LOW_WRITE |-> // [RULE_15]
    PHASE == 2'h0)
    else $error("program counter low write outside Q4");
  a_flags_after_q4: assert property (FLAGS_UPDATE |-> // [RULE_15]
    PHASE == 2'h0)
    else $error("flags update outside Q4");
  a_flags_file_only: assert property (q4_en && !is_file |=> // [RULE_07]
    !FLAGS_UPDATE)
    else $error("flags update on a non-file op");

  // the pointer is only ever touched by a Q4 write or load
  a_bp_hold: assert property (!q4_en |=> // [RULE_06]
    BANK_POINTER == $past(BANK_POINTER))
    else $error("bank pointer changed outside Q4");

  a_eff_banked: assert property (q4_en && !is_move && ACCESS_SEL |=>
    EFF_ADDR == {$past(bank_pointer), $past(OPERAND)}) // [RULE_16]
    else $error("effective address not bank pointer plus operand");
  a_fast_ext: assert property (!ACCESS_SEL && !is_move && // [RULE_13]
    EXTENDED_ISA_ENABLE && OPERAND < 8'h60 |->
    rd_addr == 12'(EXT_BASE + {4'h0, OPERAND}))
    else $error("extended fast map address wrong");

  // a move must ignore the pointer even when its source is the pointer
  a_move_read_bp: assert property (q2_en && is_move && // [RULE_08]
    SRC_ADDR == 12'hFE0 |=> RD_DATA == {4'h0, $past(bank_pointer)})
    else $error("full move read of bank pointer wrong");
  a_move_pcl: assert property (q4_en && is_move && // [RULE_14]
    DST_ADDR == 12'hFF9 |=> PC_LOW_WRITE && PC_LOW_DATA == $past(RD_DATA))
    else $error("full move to FF9h missed program counter low");

endmodule

/* File: rtl/bdm_regs.svh */
// address map, bank layout, reset values and phase codes
`ifndef BDM_REGS_SVH
`define BDM_REGS_SVH
`define BDM_ADDR_W 12
`define BDM_MEM_DEPTH 4096
`define BDM_BANKS 16
`define BDM_BANK_SIZE 256
`define BDM_BANK_IMPL 16'hFFFF
`define BDM_GPR_BANK 4'h0
`define BDM_SFR_BANK 4'hF
`define BDM_ACCESS_SPLIT 8'h60
`define BDM_BANK_PTR_ADDR 12'hFE0
`define BDM_PC_LOW_ADDR 12'hFF9
`define BDM_BP_RESET 4'h0
`define BDM_PH_Q1 2'h0
`define BDM_PH_Q2 2'h1
`define BDM_PH_Q3 2'h2
`define BDM_PH_Q4 2'h3
`endif

/* File: rtl/bdm_pkg.sv */
// types shared by the banked data memory block
package bdm_pkg;
  typedef enum logic [1:0] {
    BDM_OP_NONE,
    BDM_OP_FILE,
    BDM_OP_LOAD_BANK,
    BDM_OP_MOVE_FULL
  } bdm_op_t;
endpackage

/* File: test/bdm_core_model.sv */
// core pipeline model: one op per instruction cycle
`timescale 1ns/1ps
module bdm_core_model
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] phase,
  output bdm_op_t kind,
  output logic [62:0] f
);
  initial begin
    kind = BDM_OP_NONE;
    f = '0;
  end
  // a new op starts only at Q1 and is held through Q4
  task automatic issue(input bdm_op_t k, input logic [62:0] v,
    output bit ok);
    int n;
    n = 0;
    while (phase !== 2'h0 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = phase === 2'h0;
    kind = k;
    f = v;
    repeat (4) begin
      @(posedge clk);
      #1;
    end
  endtask
endmodule

/* File: test/bdm_top_tb.sv */
// self-checking bench for the banked data memory block
`timescale 1ns/1ps
module bdm_top_tb import bdm_pkg::*;;
  logic CLK_SYS = 0, ARST_N = 0, FLAGS_UPDATE, PC_LOW_WRITE;
  bdm_op_t kind;
  logic [62:0] f;
  logic [1:0] PHASE;
  logic [11:0] EFF_ADDR;
  logic [7:0] RD_DATA, BANK_POINTER, PC_LOW_DATA;
  logic [7:0] mem [4096];
  bit known [4096];
  logic [3:0] bp = 4'h0;
  int failures = 0, checks = 0, seed = 32'h06d01bee, r, q, i;
  initial begin
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  bdm_core_model bdm_core_model_i (.clk(CLK_SYS), .phase(PHASE),
    .kind(kind), .f(f));
  bdm_top bdm_top_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .OP_KIND(kind),
    .ACCESS_SEL(f[62]), .OPERAND(f[61:54]), .SRC_ADDR(f[53:42]),
    .DST_ADDR(f[41:30]), .LITERAL(f[29:22]), .WR_EN(f[21]),
    .WR_DATA(f[20:13]), .EXTENDED_ISA_ENABLE(f[12]), .EXT_BASE(f[11:0]),
    .PHASE(PHASE), .RD_DATA(RD_DATA), .EFF_ADDR(EFF_ADDR),
    .BANK_POINTER(BANK_POINTER), .FLAGS_UPDATE(FLAGS_UPDATE),
    .PC_LOW_WRITE(PC_LOW_WRITE), .PC_LOW_DATA(PC_LOW_DATA));
  function automatic logic [11:0] eff(logic [62:0] v);
    if (v[62]) return {bp, v[61:54]};
    if (v[61:54] >= 8'h60) return {4'hF, v[61:54]};
    return v[12] ? v[11:0] + {4'h0, v[61:54]} : {4'h0, v[61:54]};
  endfunction
  // offsets kept few so that reads often meet earlier writes
  function automatic logic [7:0] lo(logic [3:0] n);
    return {n[0] ? 4'h5 : 4'hF, 1'b1, n[3:1]};
  endfunction
  function automatic logic [62:0] mk(logic a, logic [7:0] o, logic [7:0] d);
    return {a, o, 32'h0, 1'b1, d, 13'h0};
  endfunction
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(bdm_op_t k, logic [62:0] v);
    logic [11:0] ra, wa;
    logic [7:0] er;
    bit rk, wf, ok;
    ra = k == BDM_OP_MOVE_FULL ? v[53:42] : eff(v);
    wa = k == BDM_OP_MOVE_FULL ? v[41:30] : ra;
    rk = known[ra] || ra == 12'hFE0;
    er = ra == 12'hFE0 ? {4'h0, bp} : mem[ra];
    wf = k == BDM_OP_MOVE_FULL || (k == BDM_OP_FILE && v[21]);
    bdm_core_model_i.issue(k, v, ok);
    if (!ok) begin
      failures++;
      give_verdict();
    end
    if (rk && k[0]) chk("rd_data", er, RD_DATA);
    chk("flags_update", k == BDM_OP_FILE, FLAGS_UPDATE);
    chk("pc_low_write", wf && wa == 12'hFF9, PC_LOW_WRITE);
    chk("eff_addr", wa, EFF_ADDR);
    if (wf && wa == 12'hFF9 && !k[1])
      chk("pc_low_data", v[20:13], PC_LOW_DATA);
    if (k == BDM_OP_LOAD_BANK) bp = v[25:22];
    if (wf && wa == 12'hFE0) bp = k[1] ? er[3:0] : v[16:13];
    else if (wf && wa != 12'hFF9) begin
      mem[wa] = k[1] ? er : v[20:13];
      known[wa] = k[1] ? rk : 1'b1;
    end
    chk("bank_pointer", {4'h0, bp}, BANK_POINTER);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge CLK_SYS);
    #1;
    ARST_N = 1;
    run(BDM_OP_LOAD_BANK, {33'h0, 8'hFF, 22'h0});
    run(BDM_OP_FILE, mk(1'b0, 8'h5A, 8'h11));
    run(BDM_OP_FILE, mk(1'b1, 8'h5A, 8'hA5));
    run(BDM_OP_FILE, mk(1'b0, 8'h5A, 8'h00));
    run(BDM_OP_FILE, mk(1'b1, 8'hF9, 8'h3C));
    run(BDM_OP_MOVE_FULL, {9'h0, 12'hF5A, 12'h123, 30'h0});
    run(BDM_OP_FILE, mk(1'b1, 8'hE0, 8'hE3));
    $display("test corners done");
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      q = $random(seed);
      run(bdm_op_t'(r[1:0]), {r[2], lo(r[6:3]), {4{r[7]}}, lo(r[11:8]),
        {4{r[12]}}, lo(r[16:13]), r[17] ? q[7:0] | 8'h0F : q[7:0] & 8'hF0,
        r[18], q[15:8], r[19] & r[20], {4{r[21]}}, 8'h00});
    end
    $display("test random done");
    give_verdict();
  end
endmodule
